// [src/energy_acc_pkg.sv]
// Constants, types and codes shared by the energy accumulator design
//
// Summary of operation
// - Input accumulator adds one sample averaged over four mains cycles.
// - Input accumulator and counter refresh faster than every 100 ms.
// - Output accumulator adds a 50 ms averaged sample every 50 ms.
// - Energy answers use direct format, m = 01h, R = 00h, b = 00h.
// - Coefficient query returns those fixed direct-format coefficients.
// - Energy answers travel as a block read with a PEC byte appended.
// - Accumulator wraps to its low 15 bits when the sum passes 7FFFh.
// - Sample counter steps by exactly one per accumulated sample.
// - Accumulator, wrap count and sample count are captured in one step.
// - Wrap counter is one byte and returns from FFh to 00h.
// - Sample counter is a three-byte unsigned integer.
// - Accumulated power is reported as two bytes.
// - Telemetry keeps updating in real time while the block is powered.
// - In standby with main output off, voltage and current read zero.
// - Linear value is 11-bit signed mantissa plus 5-bit signed exponent.
// - Linear value equals mantissa times two to the exponent.
// - Linear-format consumers handle every possible exponent value.
// - Output voltage mode writes are refused and flag invalid data.
package energy_acc_pkg;

    // Clock and timing
    localparam int CLK_HZ = 20_000_000;
    localparam int EOUT_PERIOD_MS = 50;
    localparam int EIN_LIMIT_MS = 100;
    localparam int EOUT_PERIOD_CYC = CLK_HZ / 1000 * EOUT_PERIOD_MS;
    localparam int EIN_LIMIT_CYC = CLK_HZ / 1000 * EIN_LIMIT_MS;
    localparam int EIN_CYCLES = 4;
    localparam int TMR_W = 21;

    // Command codes
    localparam logic [7:0] CMD_READ_EIN = 8'h86;
    localparam logic [7:0] CMD_READ_EOUT = 8'h87;
    localparam logic [7:0] CMD_COEF = 8'h30;
    localparam logic [7:0] CMD_VOUT_MODE = 8'h20;

    // Fixed direct-format coefficients
    localparam logic [15:0] COEF_M = 16'h0001;
    localparam logic [15:0] COEF_B = 16'h0000;
    localparam logic [7:0] COEF_R = 8'h00;

    // Block lengths, the PEC polynomial and the power saturation limit
    localparam logic [7:0] EN_COUNT = 8'h06;
    localparam logic [7:0] COEF_COUNT = 8'h05;
    localparam logic [7:0] PEC_POLY = 8'h07;
    localparam logic [14:0] PWR_MAX = 15'h7FFF;

    // Communication status bit positions
    localparam int CML_INV_CMD = 7;
    localparam int CML_INV_DATA = 6;

    // Accumulator channels
    localparam int CH_IN = 0;
    localparam int CH_OUT = 1;

    typedef enum logic [0:0] {
        ST_IDLE,
        ST_SEND
    } resp_state_e;

    typedef struct packed {
        logic [23:0] cnt;
        logic [7:0] wrap;
        logic [14:0] pwr;
    } energy_s;

    typedef struct packed {
        logic [15:0] vout;
        logic [15:0] iout;
    } telemetry_s;

endpackage

// [src/power_energy_accumulator.sv]
// Input and output energy accumulators with block-read answer stream
`timescale 1ns/1ns
`default_nettype none

module power_energy_accumulator
    import energy_acc_pkg::*;
#(
    parameter int EOUT_PERIOD = EOUT_PERIOD_CYC,
    parameter int EIN_LIMIT = EIN_LIMIT_CYC
) (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic reset_n_i,
    // Bus address of this device
    input wire logic [6:0] dev_addr_i,
    // Power samples
    input wire logic [14:0] pin_avg_i,
    input wire logic mains_cycle_i,
    input wire logic [15:0] pout_lin_i,
    // Telemetry
    input wire logic main_on_i,
    input wire telemetry_s tel_raw_i,
    output telemetry_s tel_o,
    // Read query
    input wire logic query_valid_i,
    input wire logic [7:0] query_cmd_i,
    output logic query_ready_o,
    // Answer byte stream
    output logic resp_valid_o,
    output logic [7:0] resp_data_o,
    output logic resp_last_o,
    input wire logic resp_ready_i,
    // Writes and status
    input wire logic wr_valid_i,
    input wire logic [7:0] wr_cmd_i,
    input wire logic [7:0] cml_clear_i,
    output logic [7:0] communication_status_o,
    output logic ein_late_o
);

    typedef struct packed {
        resp_state_e st;
        energy_s [1:0] acc;
        logic [1:0] cyc;
        logic [TMR_W-1:0] tmr;
        logic [TMR_W-1:0] wdog;
        logic late;
        logic [7:0][7:0] shift;
        logic [3:0] left;
        telemetry_s tel;
        logic [7:0] cml;
    } state_s;

    state_s s;
    state_s next_s;
    logic [1:0] add;
    logic [1:0][14:0] smp;

    // One PEC step, CRC-8 with polynomial x^8 + x^2 + x + 1
    function automatic logic [7:0] crc8(input logic [7:0] c,
                                        input logic [7:0] d);
        logic [7:0] r;
        r = c ^ d;
        for (int i = 0; i < 8; i++) begin
            r = r[7] ? ({r[6:0], 1'b0} ^ PEC_POLY) : {r[6:0], 1'b0};
        end
        return r;
    endfunction

    // Linear value to whole watts; any exponent, negatives clamp to zero
    function automatic logic [14:0] lin_to_int(input logic [15:0] v);
        logic [31:0] base;
        logic [31:0] mag;
        logic [5:0] sh;
        base = {21'h000000, v[10:0]};
        sh = ~{v[15], v[15:11]} + 6'h01;
        mag = 32'h00000000;
        if (v[10]) begin
            mag = 32'h00000000; // negative power carries no energy
        end else if (!v[15]) begin
            mag = base << v[14:11];
        end else begin
            mag = base >> sh; // down to 2^-16
        end
        return (mag > {17'h00000, PWR_MAX}) ? PWR_MAX : mag[14:0];
    endfunction

    // Add a sample; the sum keeps its low 15 bits and counts the wrap
    function automatic energy_s accumulate(input energy_s e,
                                           input logic [14:0] p);
        energy_s r;
        logic [15:0] sum;
        sum = {1'b0, e.pwr} + {1'b0, p};
        r.pwr = sum[14:0];
        r.wrap = sum[15] ? e.wrap + 8'h01 : e.wrap; // FFh to 00h
        r.cnt = e.cnt + 24'h000001;
        return r;
    endfunction

    // Sample strobes: every fourth mains cycle in, timer period out
    assign add[CH_IN] = mains_cycle_i
        && (s.cyc == 2'(EIN_CYCLES - 1));
    assign add[CH_OUT] = (s.tmr == TMR_W'(EOUT_PERIOD - 1));
    assign smp[CH_IN] = pin_avg_i;
    assign smp[CH_OUT] = lin_to_int(pout_lin_i);

    // Next-state logic for the whole block
    always_comb begin
        logic [7:0][7:0] pay;
        logic [3:0] plen;
        logic [7:0] pec;
        energy_s snap;
        pay = '0;
        plen = 4'h0;
        pec = 8'h00;
        snap = '0;
        next_s = s;

        // Telemetry refreshes every cycle; main output reads zero when off
        next_s.tel = main_on_i ? tel_raw_i : '0;

        // Mains cycle count and the input refresh watchdog
        if (mains_cycle_i) begin
            next_s.cyc = add[CH_IN] ? 2'h0 : s.cyc + 2'h1;
        end
        if (add[CH_IN]) begin
            next_s.wdog = '0;
            next_s.late = 1'b0;
        end else if (s.wdog == TMR_W'(EIN_LIMIT - 1)) begin
            next_s.late = 1'b1; // no refresh within the limit
        end else begin
            next_s.wdog = s.wdog + TMR_W'(1);
        end
        next_s.tmr = add[CH_OUT] ? '0 : s.tmr + TMR_W'(1);

        // Both accumulators share one update path
        for (int ch = 0; ch < 2; ch++) begin
            if (add[ch]) begin
                next_s.acc[ch] = accumulate(s.acc[ch], smp[ch]);
            end
        end

        // Status clears first so a same-cycle event still lands
        next_s.cml = s.cml & ~cml_clear_i;
        if (wr_valid_i && wr_cmd_i == CMD_VOUT_MODE) begin
            next_s.cml[CML_INV_DATA] = 1'b1;
        end

        // Answer stream
        unique case (s.st)
            ST_IDLE: begin
                if (query_valid_i) begin
                    if (query_cmd_i == CMD_READ_EIN
                        || query_cmd_i == CMD_READ_EOUT) begin
                        // Pre-update values: all three fields agree
                        snap = query_cmd_i[0] ? s.acc[CH_OUT]
                                              : s.acc[CH_IN];
                        pay[0] = EN_COUNT;
                        pay[1] = snap.pwr[7:0];
                        pay[2] = {1'b0, snap.pwr[14:8]};
                        pay[3] = snap.wrap;
                        pay[4] = snap.cnt[7:0];
                        pay[5] = snap.cnt[15:8];
                        pay[6] = snap.cnt[23:16];
                        plen = 4'h7;
                    end else if (query_cmd_i == CMD_COEF) begin
                        pay[0] = COEF_COUNT;
                        pay[1] = COEF_M[7:0];
                        pay[2] = COEF_M[15:8];
                        pay[3] = COEF_B[7:0];
                        pay[4] = COEF_B[15:8];
                        pay[5] = COEF_R;
                        plen = 4'h6;
                    end else begin
                        next_s.cml[CML_INV_CMD] = 1'b1;
                    end
                    if (plen != 4'h0) begin
                        // PEC covers write address, command, read address and the payload bytes
                        pec = crc8(8'h00, {dev_addr_i, 1'b0});
                        pec = crc8(pec, query_cmd_i);
                        pec = crc8(pec, {dev_addr_i, 1'b1});
                        for (int i = 0; i < 7; i++) begin
                            if (4'(i) < plen) begin
                                pec = crc8(pec, pay[i]);
                            end
                        end
                        pay[plen[2:0]] = pec;
                        next_s.shift = pay;
                        next_s.left = plen + 4'h1;
                        next_s.st = ST_SEND;
                    end
                end
            end
            ST_SEND: begin
                if (resp_ready_i) begin
                    next_s.shift = {8'h00, s.shift[7:1]};
                    next_s.left = s.left - 4'h1;
                    if (s.left == 4'h1) begin
                        next_s.st = ST_IDLE;
                    end
                end
            end
        endcase
    end

    // State register
    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    // Outputs; the stream handshake is decoded from state
    assign query_ready_o = (s.st == ST_IDLE);
    assign resp_valid_o = (s.st == ST_SEND);
    assign resp_last_o = (s.st == ST_SEND) && (s.left == 4'h1);
    assign resp_data_o = s.shift[0];
    assign tel_o = s.tel;
    assign communication_status_o = s.cml;
    assign ein_late_o = s.late;

    // Checks
    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (!reset_n_i);

    acc_wrap_a: assert property (
        add[CH_IN] && ({1'b0, s.acc[CH_IN].pwr} + {1'b0, pin_avg_i}) > 16'h7FFF
        |=> s.acc[CH_IN].wrap == $past(s.acc[CH_IN].wrap) + 8'h01)
        else $error("Input wrap count did not step on overflow");

    count_step_a: assert property (
        add[CH_OUT] |=> s.acc[CH_OUT].cnt == $past(s.acc[CH_OUT].cnt) + 24'h1)
        else $error("Output sample count did not step by one");

    ein_fourth_a: assert property (
        mains_cycle_i && s.cyc == 2'h3
        |=> s.acc[CH_IN].cnt == $past(s.acc[CH_IN].cnt) + 24'h1)
        else $error("Input sample not taken on the fourth mains cycle");

    ein_hold_a: assert property (
        !mains_cycle_i |=> $stable(s.acc[CH_IN]))
        else $error("Input accumulator moved without a mains cycle");

    eout_period_a: assert property (
        add[CH_OUT] |=> s.tmr == '0 ##1 s.tmr == TMR_W'(1))
        else $error("Output sample timer did not restart");

    ein_late_a: assert property (
        s.wdog == TMR_W'(EIN_LIMIT - 1) && !add[CH_IN] |=> ein_late_o)
        else $error("Missing input refresh not flagged");

    snap_a: assert property (
        query_ready_o && query_valid_i && query_cmd_i == CMD_READ_EIN
        |=> resp_data_o == EN_COUNT
            && s.shift[1] == $past(s.acc[CH_IN].pwr[7:0])
            && s.shift[4] == $past(s.acc[CH_IN].cnt[7:0]))
        else $error("Energy snapshot does not match accumulator");

    coef_a: assert property (
        query_ready_o && query_valid_i && query_cmd_i == CMD_COEF
        |=> s.shift[1] == 8'h01 && s.shift[5] == 8'h00 && s.left == 4'h7)
        else $error("Coefficient answer is wrong");

    stream_len_a: assert property (
        query_ready_o && query_valid_i && query_cmd_i == CMD_READ_EOUT
        ##1 (resp_ready_i [*8]) |-> resp_last_o && resp_valid_o)
        else $error("Energy block read is not eight bytes long");

    standby_a: assert property (
        !main_on_i |=> tel_o == '0)
        else $error("Main output telemetry not zero in standby");

    cml_set_a: assert property (
        wr_valid_i && wr_cmd_i == CMD_VOUT_MODE |=> communication_status_o[6])
        else $error("Refused write did not flag invalid data");

    ein_read_c: cover property (
        query_valid_i && query_ready_o && query_cmd_i == CMD_READ_EIN
        ##1 resp_valid_o [*8] ##1 query_ready_o);
    coef_read_c: cover property (
        query_valid_i && query_ready_o && query_cmd_i == CMD_COEF);
    wrap_c: cover property (
        s.acc[CH_IN].wrap != $past(s.acc[CH_IN].wrap));
    cml_race_c: cover property (
        wr_valid_i && wr_cmd_i == CMD_VOUT_MODE && cml_clear_i[6]);

endmodule

`default_nettype wire

// [test/host_poll_model.sv]
// Host bus controller model polling the energy answers
`timescale 1ns/1ns
`default_nettype none

module host_poll_model (
    // Clock
    input wire logic clk_sys_i,
    // Query request
    output logic query_valid_o,
    output logic [7:0] query_cmd_o,
    input wire logic query_ready_i,
    // Answer stream
    input wire logic resp_valid_i,
    input wire logic [7:0] resp_data_i,
    input wire logic resp_last_i,
    output logic resp_ready_o
);
    // Answer bytes, first byte lowest, and their count
    logic [63:0] rx = '0;
    int n = 0;

    initial begin
        query_valid_o = 1'b0;
        query_cmd_o = 8'h00;
        resp_ready_o = 1'b0;
    end

    // One block read; the caller may let up to 255 wraps pass between polls
    task automatic poll(input logic [7:0] cmd, input logic slow);
        logic done;
        done = 1'b0;
        rx = '0;
        n = 0;
        @(posedge clk_sys_i);
        query_valid_o <= 1'b1;
        query_cmd_o <= cmd;
        for (int w = 0; w < 20 && !done; w++) begin
            @(negedge clk_sys_i);
            done = query_ready_i;
            @(posedge clk_sys_i);
        end
        // Released command shows junk, not its last value
        query_valid_o <= 1'b0;
        query_cmd_o <= ~cmd;
        done = 1'b0;
        for (int w = 0; w < 40 && !done; w++) begin
            // A slow host takes a byte every other cycle only
            resp_ready_o <= !slow || w[0];
            @(negedge clk_sys_i);
            if (resp_valid_i && resp_ready_o && n < 8) begin
                rx[8*n +: 8] = resp_data_i;
                n++;
                done = resp_last_i;
            end
            @(posedge clk_sys_i);
        end
        resp_ready_o <= 1'b0;
    endtask
endmodule

`default_nettype wire

// [test/power_energy_accumulator_tb_top.sv]
// Self-checking bench for the energy accumulator answers
`timescale 1ns/1ns
`default_nettype none

module power_energy_accumulator_tb_top;
    import energy_acc_pkg::*;

    // Short periods keep the run brief
    localparam int EOUT_P = 20;
    localparam int EIN_L = 100;
    localparam logic [6:0] ADDR = 7'h5A;
    localparam int LIMIT = 20000;

    logic clk_sys_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic mains_cycle_i = 1'b0;
    logic main_on_i = 1'b0;
    logic wr_valid_i = 1'b0;
    logic [14:0] pin_avg_i = 15'h0000;
    logic [15:0] pout_lin_i = 16'h0000;
    logic [7:0] wr_cmd_i = 8'h00;
    logic [7:0] cml_clear_i = 8'h00;
    telemetry_s tel_raw_i = '0;
    telemetry_s tel_o;
    logic query_valid_i, query_ready_o, resp_valid_o, resp_last_o;
    logic resp_ready_i, ein_late_o;
    logic [7:0] query_cmd_i, resp_data_o, communication_status_o;
    int mismatches = 0;
    int tests_run = 0;
    int cycles = 0;

    always #25 clk_sys_i = ~clk_sys_i;

    power_energy_accumulator #(.EOUT_PERIOD(EOUT_P), .EIN_LIMIT(EIN_L)) dut (
        .clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .dev_addr_i(ADDR),
        .pin_avg_i(pin_avg_i), .mains_cycle_i(mains_cycle_i),
        .pout_lin_i(pout_lin_i), .main_on_i(main_on_i),
        .tel_raw_i(tel_raw_i), .tel_o(tel_o),
        .query_valid_i(query_valid_i), .query_cmd_i(query_cmd_i),
        .query_ready_o(query_ready_o), .resp_valid_o(resp_valid_o),
        .resp_data_o(resp_data_o), .resp_last_o(resp_last_o),
        .resp_ready_i(resp_ready_i), .wr_valid_i(wr_valid_i),
        .wr_cmd_i(wr_cmd_i), .cml_clear_i(cml_clear_i),
        .communication_status_o(communication_status_o),
        .ein_late_o(ein_late_o)
    );

    host_poll_model host (
        .clk_sys_i(clk_sys_i), .query_valid_o(query_valid_i),
        .query_cmd_o(query_cmd_i), .query_ready_i(query_ready_o),
        .resp_valid_i(resp_valid_o), .resp_data_i(resp_data_o),
        .resp_last_i(resp_last_o), .resp_ready_o(resp_ready_i)
    );

    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        tests_run++;
        if (seen !== exp) begin
            mismatches++;
            $display("CHECK FAILED at %0t seen %h expected %h",
                $time, seen, exp);
        end
    endtask

    function automatic logic [7:0] crc8(input logic [7:0] c,
        input logic [7:0] d);
        logic [7:0] r;
        r = c ^ d;
        for (int i = 0; i < 8; i++) begin
            r = r[7] ? {r[6:0], 1'b0} ^ PEC_POLY : {r[6:0], 1'b0};
        end
        return r;
    endfunction

    // Whole answer: count byte, data bytes, then PEC over the transaction
    task automatic check_frame(input logic [7:0] cmd, input logic [7:0] len,
        input logic [47:0] data);
        logic [7:0] pec;
        logic [63:0] exp;
        pec = crc8(crc8(crc8(8'h00, {ADDR, 1'b0}), cmd), {ADDR, 1'b1});
        pec = crc8(pec, len);
        exp = {56'h0, len};
        for (int i = 0; i < 6; i++) begin
            if (i < len) begin
                exp[8*i+8 +: 8] = data[8*i +: 8];
                pec = crc8(pec, data[8*i +: 8]);
            end
        end
        exp[8*len+8 +: 8] = pec;
        check(host.rx, exp);
        check(host.n, len + 2);
    endtask

    // Four mains pulses make one averaged input sample
    task automatic add_in(input logic [14:0] p);
        @(posedge clk_sys_i);
        pin_avg_i <= p;
        repeat (4) begin
            mains_cycle_i <= 1'b1;
            @(posedge clk_sys_i);
            mains_cycle_i <= 1'b0;
            @(posedge clk_sys_i);
        end
    endtask

    task automatic do_reset();
        reset_n_i <= 1'b0;
        repeat (2) @(posedge clk_sys_i);
        reset_n_i <= 1'b1;
    endtask

    // Ends at a falling edge so status is settled for the caller
    task automatic pulse(input logic wr, input logic [7:0] c,
        input logic [7:0] clr);
        @(posedge clk_sys_i);
        wr_valid_i <= wr;
        wr_cmd_i <= c;
        cml_clear_i <= clr;
        @(posedge clk_sys_i);
        wr_valid_i <= 1'b0;
        cml_clear_i <= 8'h00;
        @(negedge clk_sys_i);
    endtask

    task automatic test_input();
        host.poll(CMD_READ_EIN, 1'b0);
        check_frame(CMD_READ_EIN, 8'h06, 48'h0);
        repeat (3) add_in(15'h4000);
        host.poll(CMD_READ_EIN, 1'b0);
        check_frame(CMD_READ_EIN, 8'h06,
            {24'h000003, 8'h01, 16'h4000});
        // A sample lands while a slow answer is still streaming
        fork
            host.poll(CMD_READ_EIN, 1'b1);
            add_in(15'h4000);
        join
        check_frame(CMD_READ_EIN, 8'h06,
            {24'h000003, 8'h01, 16'h4000});
        // 513 samples in all: 256 wraps bring the wrap count back to 00h
        repeat (509) add_in(15'h4000);
        host.poll(CMD_READ_EIN, 1'b0);
        check_frame(CMD_READ_EIN, 8'h06,
            {24'h000201, 8'h00, 16'h4000});
        $display("test_input done");
    endtask

    task automatic test_output();
        // Mantissa 300 with exponent -1 gives 150 W per sample
        pout_lin_i <= {5'h1F, 11'h12C};
        do_reset();
        repeat (50) @(posedge clk_sys_i);
        host.poll(CMD_READ_EOUT, 1'b0);
        check_frame(CMD_READ_EOUT, 8'h06,
            {24'h000002, 8'h00, 16'h012C});
        // Host side average: accumulated power over sample count
        check(host.rx[23:8] / host.rx[55:32], 64'h96);
        repeat (8) @(posedge clk_sys_i);
        // Negative mantissa adds nothing but still counts
        pout_lin_i <= {5'h00, 11'h7FF};
        repeat (40) @(posedge clk_sys_i);
        @(negedge clk_sys_i);
        check(ein_late_o, 1'b1);
        host.poll(CMD_READ_EOUT, 1'b0);
        check_frame(CMD_READ_EOUT, 8'h06,
            {24'h000005, 8'h00, 16'h01C2});
        add_in(15'h0010);
        repeat (2) @(posedge clk_sys_i);
        @(negedge clk_sys_i);
        check(ein_late_o, 1'b0);
        // Large positive exponent saturates to 7FFFh, then the sum wraps
        @(posedge clk_sys_i);
        pout_lin_i <= {5'h0F, 11'h3FF};
        repeat (20) @(posedge clk_sys_i);
        host.poll(CMD_READ_EOUT, 1'b0);
        check_frame(CMD_READ_EOUT, 8'h06,
            {24'h000007, 8'h01, 16'h01C1});
        $display("test_output done");
    endtask

    task automatic test_coef();
        host.poll(CMD_COEF, 1'b1);
        check_frame(CMD_COEF, 8'h05, 48'h1);
        $display("test_coef done");
    endtask

    task automatic test_status();
        pulse(1'b1, 8'h21, 8'h00);
        check(communication_status_o, 8'h00);
        pulse(1'b1, CMD_VOUT_MODE, 8'h00);
        check(communication_status_o, 8'h40);
        pulse(1'b1, CMD_VOUT_MODE, 8'h40);
        check(communication_status_o, 8'h40);
        pulse(1'b0, 8'h00, 8'h40);
        check(communication_status_o, 8'h00);
        // Unknown query: no block read, invalid command flag instead
        host.poll(8'h21, 1'b0);
        check(host.n, 0);
        check(communication_status_o, 8'h80);
        $display("test_status done");
    endtask

    task automatic test_telemetry();
        @(posedge clk_sys_i);
        main_on_i <= 1'b1;
        tel_raw_i <= 32'h1234_5678;
        @(posedge clk_sys_i);
        @(negedge clk_sys_i);
        check(tel_o, 32'h1234_5678);
        @(posedge clk_sys_i);
        main_on_i <= 1'b0;
        @(posedge clk_sys_i);
        @(negedge clk_sys_i);
        check(tel_o, 32'h0);
        $display("test_telemetry done");
    endtask

    task automatic final_report();
        $display("Comparisons %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // A hang counts as a mismatch and still reaches the report
    always @(posedge clk_sys_i) begin
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            mismatches++;
            final_report();
        end
    end

    initial begin
        do_reset();
        test_input();
        test_output();
        test_coef();
        test_status();
        test_telemetry();
        final_report();
    end
endmodule

`default_nettype wire
